// file: design/asp_pkg.sv
package asp_pkg;

	// Width of one analog input configuration byte.
	localparam int unsigned ASP_CFG_W = 8;
	// Position of the start marker inside the configuration byte.
	localparam int unsigned ASP_START_POS = 7;
	// Width of one conversion result.
	localparam int unsigned ASP_RES_W = 16;
	// Bit counter width, enough to count a whole result.
	localparam int unsigned ASP_CNT_W = 5;
	localparam logic [ASP_CNT_W-1:0] ASP_CNT_RST = 5'h00;
	localparam logic [ASP_CNT_W-1:0] ASP_CFG_LAST = 5'h07;
	localparam logic [ASP_RES_W-1:0] ASP_RES_RST = 16'h0000;
	localparam logic [ASP_CFG_W-1:0] ASP_CFG_RST = 8'h00;
	// Strobe pulse length in nanoseconds.
	localparam int unsigned ASP_STRB_NS = 100;
	localparam int unsigned ASP_CLK_NS = 20;
	localparam logic [3:0] ASP_STRB_CYC = 4'((ASP_STRB_NS + ASP_CLK_NS - 1) / ASP_CLK_NS);

	typedef struct packed {
		logic sclk;
		logic din;
		logic cs_n;
	} asp_pins_t;

	typedef struct packed {
		logic sclk_rise;
		logic sclk_fall;
		logic sel;
		logic sel_fall;
		logic din;
	} asp_evt_t;

	typedef enum logic [1:0] {
		ASP_HUNT,
		ASP_CFG,
		ASP_DATA
	} asp_state_t;

endpackage

// file: design/asp_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for the serial pins, followed by edge detection on
// the second stage only.
module asp_sync
	import asp_pkg::*;
(
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire asp_pins_t pins_in,
	output asp_evt_t evt_out
);
	asp_pins_t meta_q;
	asp_pins_t meta_d;
	asp_pins_t sync_q;
	asp_pins_t sync_d;
	asp_pins_t prev_q;
	asp_pins_t prev_d;

	always_comb begin
		meta_d = pins_in;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_q <= '{sclk: 1'b0, din: 1'b0, cs_n: 1'b1};
			sync_q <= '{sclk: 1'b0, din: 1'b0, cs_n: 1'b1};
			prev_q <= '{sclk: 1'b0, din: 1'b0, cs_n: 1'b1};
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	always_comb begin
		evt_out.sclk_rise = sync_q.sclk & ~prev_q.sclk;
		evt_out.sclk_fall = ~sync_q.sclk & prev_q.sclk;
		evt_out.sel = ~sync_q.cs_n;
		evt_out.sel_fall = ~sync_q.cs_n & prev_q.cs_n;
		evt_out.din = sync_q.din;
	end
endmodule

// file: design/asp_port.sv
`timescale 1ns/1ps
// Functional notes
// - Sample input bit on rising clock while selected
// - Shift output bit on each falling clock, except in the select cycle
// - Deselected: ignore clock, data; output released
// - Internal clock: rising strobe marks ready result
// - External clock mode: strobe held low always
// - Strobe output always driven, never released
// - First one after select starts config byte
module asp_port
	import asp_pkg::*;
(
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic din_in,
	input wire logic int_clk_mode_in,
	input wire logic result_valid_in,
	input wire logic [ASP_RES_W-1:0] result_in,
	output logic dout_out,
	output logic dout_oe_out,
	output logic result_ready_flag_out,
	output logic [ASP_CFG_W-1:0] cfg_byte_out,
	output logic cfg_valid_out
);
	asp_evt_t evt;
	asp_pins_t pins;

	asp_state_t state_q;
	asp_state_t state_d;
	logic [ASP_CNT_W-1:0] cnt_q;
	logic [ASP_CNT_W-1:0] cnt_d;
	logic [ASP_CFG_W-1:0] sh_in_q;
	logic [ASP_CFG_W-1:0] sh_in_d;
	logic [ASP_RES_W-1:0] sh_out_q;
	logic [ASP_RES_W-1:0] sh_out_d;
	logic [ASP_RES_W-1:0] hold_q;
	logic [ASP_RES_W-1:0] hold_d;
	logic dout_q;
	logic dout_d;
	logic oe_q;
	logic oe_d;
	logic [ASP_CFG_W-1:0] cfg_q;
	logic [ASP_CFG_W-1:0] cfg_d;
	logic cfg_v_q;
	logic cfg_v_d;
	logic [3:0] strb_cnt_q;
	logic [3:0] strb_cnt_d;
	logic strb_q;
	logic strb_d;

	always_comb begin
		pins.sclk = sclk_in;
		pins.din = din_in;
		pins.cs_n = cs_n_in;
	end

	asp_sync u_sync (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.pins_in(pins),
		.evt_out(evt)
	);

	// Serial shift path.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_in_d = sh_in_q;
		sh_out_d = sh_out_q;
		hold_d = result_valid_in ? result_in : hold_q;
		dout_d = dout_q;
		oe_d = evt.sel;
		cfg_d = cfg_q;
		cfg_v_d = 1'b0;
		if (!evt.sel) begin
			state_d = ASP_HUNT;
			cnt_d = ASP_CNT_RST;
			dout_d = 1'b0;
		end else begin
			if (evt.sel_fall) begin
				state_d = ASP_HUNT;
				cnt_d = ASP_CNT_RST;
				sh_out_d = hold_q;
				dout_d = hold_q[ASP_RES_W-1];
			end
			if (evt.sclk_rise) begin
				case (state_q)
					ASP_HUNT: begin
						if (evt.din) begin
							// Marker already fills the lowest bit position.
							state_d = ASP_CFG;
							sh_in_d = ASP_CFG_RST | 8'h01;
							cnt_d = 5'h01;
						end
					end
					ASP_CFG: begin
						sh_in_d = {sh_in_q[ASP_CFG_W-2:0], evt.din};
						cnt_d = cnt_q + 5'h01;
						if (cnt_q == ASP_CFG_LAST) begin
							state_d = ASP_DATA;
							cfg_d = {sh_in_q[ASP_CFG_W-2:0], evt.din};
							cfg_v_d = 1'b1;
						end
					end
					ASP_DATA: begin
					end
					default: state_d = ASP_HUNT;
				endcase
			end
			if (evt.sclk_fall && !evt.sel_fall) begin
				sh_out_d = {sh_out_q[ASP_RES_W-2:0], 1'b0};
				dout_d = sh_out_q[ASP_RES_W-2];
			end
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q <= ASP_HUNT;
			cnt_q <= ASP_CNT_RST;
			sh_in_q <= ASP_CFG_RST;
			sh_out_q <= ASP_RES_RST;
			hold_q <= ASP_RES_RST;
			dout_q <= 1'b0;
			oe_q <= 1'b0;
			cfg_q <= ASP_CFG_RST;
			cfg_v_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sh_in_q <= sh_in_d;
			sh_out_q <= sh_out_d;
			hold_q <= hold_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
			cfg_q <= cfg_d;
			cfg_v_q <= cfg_v_d;
		end
	end

	// Strobe path; it is a plain output so it can never float.
	always_comb begin
		strb_cnt_d = strb_cnt_q;
		strb_d = strb_q;
		if (!int_clk_mode_in) begin
			strb_cnt_d = 4'h0;
			strb_d = 1'b0;
		end else if (result_valid_in) begin
			// The loading cycle is already the first cycle of the pulse, so count one less.
			strb_cnt_d = ASP_STRB_CYC - 4'h1;
			strb_d = 1'b1;
		end else if (strb_cnt_q != 4'h0) begin
			strb_cnt_d = strb_cnt_q - 4'h1;
			strb_d = 1'b1;
		end else begin
			strb_d = 1'b0;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			strb_cnt_q <= 4'h0;
			strb_q <= 1'b0;
		end else begin
			strb_cnt_q <= strb_cnt_d;
			strb_q <= strb_d;
		end
	end

	always_comb begin
		dout_out = dout_q;
		dout_oe_out = oe_q;
		result_ready_flag_out = strb_q;
		cfg_byte_out = cfg_q;
		cfg_valid_out = cfg_v_q;
	end

	chk_release_when_idle: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		!evt.sel |=> !dout_oe_out)
		else $error("output enabled while deselected");

	chk_strobe_ext_low: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		!int_clk_mode_in |=> !result_ready_flag_out)
		else $error("strobe high in external clock mode");

	chk_strobe_rises: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		int_clk_mode_in && result_valid_in |=> result_ready_flag_out)
		else $error("strobe missing after result");

	chk_shift_on_fall: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		evt.sel && evt.sclk_fall && !evt.sel_fall |=> dout_out == $past(sh_out_q[ASP_RES_W-2]))
		else $error("output did not shift on falling clock");

	chk_cfg_after_start: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		cfg_valid_out |-> cfg_byte_out[ASP_START_POS])
		else $error("config byte lacks start marker");

	chk_hunt_holds: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		state_q == ASP_HUNT && evt.sclk_rise && !evt.din && evt.sel |=> state_q == ASP_HUNT)
		else $error("zero bit left hunt state");

	chk_strobe_needs_result: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		$rose(result_ready_flag_out) |-> $past(result_valid_in) && $past(int_clk_mode_in))
		else $error("strobe rose without a ready result");

	chk_select_first_bit: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		evt.sel_fall |=> dout_out == $past(hold_q[ASP_RES_W-1]))
		else $error("first result bit missing at select");

	chk_drive_when_selected: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		evt.sel |=> dout_oe_out)
		else $error("output not driven while selected");

	chk_deselect_ignores: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		!evt.sel |=> state_q == ASP_HUNT && !cfg_valid_out)
		else $error("activity taken while deselected");

	chk_cfg_single_pulse: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		cfg_valid_out |=> !cfg_valid_out)
		else $error("config valid longer than one cycle");
endmodule

// file: tb/asp_host_model.sv
`timescale 1ns/1ps
module asp_host_model (
	output logic cs_n_out,
	output logic sclk_out,
	output logic din_out,
	input wire logic dout_in,
	output logic [15:0] rx_word_out,
	output logic rx_stb_out
);
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		din_out = 1'b0;
		rx_word_out = 16'h0000;
		rx_stb_out = 1'b0;
	end
	// The 3 ns lead keeps every link edge clear of a system clock edge.
	task automatic frame(input logic [15:0] bits);
		#3 cs_n_out = 1'b0;
		#100;
		for (int i = 15; i >= 0; i--) begin
			din_out = bits[i];
			#80 sclk_out = 1'b1;
			rx_word_out[i] = dout_in;
			#80 sclk_out = 1'b0;
		end
		din_out = ~din_out;
		#80 cs_n_out = 1'b1;
		rx_stb_out = 1'b1;
		#20 rx_stb_out = 1'b0;
	endtask
	task automatic noise(input logic [7:0] pat);
		for (int i = 0; i < 8; i++) begin
			#3 din_out = pat[i];
			#77 sclk_out = 1'b1;
			#80 sclk_out = 1'b0;
		end
	endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
	import asp_pkg::*;
	logic clock_in, sys_rst_in, int_clk_mode_in, result_valid_in;
	logic [ASP_RES_W-1:0] result_in, r, bits, rx_word;
	logic cs_n, sclk, din, dout, dout_oe, flag, cfg_valid, rx_stb;
	logic [ASP_CFG_W-1:0] cfg_byte;
	logic [23:0] v;
	logic [31:0] seed = 32'h04cd;
	int error_cnt = 0, total_checks = 0, cycles = 0, n, lead;
	logic [15:0] word_q[$];
	logic [7:0] cfg_q[$];
	wire dout_pin = dout_oe ? dout : 1'bz;
	asp_port dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n),
		.sclk_in(sclk), .din_in(din), .int_clk_mode_in(int_clk_mode_in),
		.result_valid_in(result_valid_in), .result_in(result_in), .dout_out(dout),
		.dout_oe_out(dout_oe), .result_ready_flag_out(flag), .cfg_byte_out(cfg_byte),
		.cfg_valid_out(cfg_valid));
	asp_host_model host_u (.cs_n_out(cs_n), .sclk_out(sclk), .din_out(din),
		.dout_in(dout_pin), .rx_word_out(rx_word), .rx_stb_out(rx_stb));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// A configuration byte nobody announced compares against unknown and so fails.
	always @(posedge clock_in) if (cfg_valid === 1'b1) begin
		check(16'(cfg_byte), cfg_q.size() > 0 ? 16'(cfg_q.pop_front()) : 16'hxxxx);
	end
	always @(posedge rx_stb) check(rx_word, word_q.pop_front());
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 8000) begin
			error_cnt++;
			end_sim();
		end
	end
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	initial begin
		sys_rst_in = 1'b1;
		int_clk_mode_in = 1'b0;
		result_valid_in = 1'b0;
		result_in = 16'h0000;
		repeat (20) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		for (int k = 0; k < 12; k++) begin
			int_clk_mode_in <= k[0];
			@(posedge clock_in);
			r = 16'(xs());
			result_in <= r;
			result_valid_in <= 1'b1;
			@(posedge clock_in);
			result_valid_in <= 1'b0;
			n = 0;
			repeat (10) begin
				@(posedge clock_in);
				n += int'(flag === 1'b1);
			end
			check(16'(n), k[0] ? 16'(ASP_STRB_CYC) : 16'h0000);
			word_q.push_back(r);
			v = 24'(xs()) | 24'h800000;
			lead = k % 9;
			bits = (k == 11) ? 16'h0000 : 16'(v >> (8 + lead));
			if (k != 11) cfg_q.push_back(v[23:16]);
			host_u.frame(bits);
			repeat (6) @(posedge clock_in);
			check(16'(dout_oe), 16'h0000);
			host_u.noise(8'(xs()));
			repeat (6) @(posedge clock_in);
			check(16'(dout_oe), 16'h0000);
			check(16'(flag), 16'h0000);
		end
		check(16'(word_q.size()), 16'h0000);
		check(16'(cfg_q.size()), 16'h0000);
		end_sim();
	end
endmodule
